// >>> rtl/cah_pkg.sv
package cah_pkg;
    // Service codes for the optional route services
    localparam logic [7:0] CAH_SVC_ADD_ROUTE = 8'h4B;
    localparam logic [7:0] CAH_SVC_DEL_ROUTE = 8'h4C;
    // Module clock
    localparam int CAH_CLK_MHZ = 250;
    // Default acknowledgement time-out, in milliseconds
    localparam int CAH_ACK_TMO_MS = 16;
    localparam logic [31:0] CAH_ACK_TMO_CYC =
        32'(CAH_ACK_TMO_MS * 1000 * CAH_CLK_MHZ);
    localparam logic [7:0] CAH_RETRY_LIM_DEF = 8'h01;
    // Connection slots tracked
    localparam int CAH_NCONN = 4;
    localparam int CAH_ROUTE_BYTES = 8;
    // Register byte offsets
    localparam logic [7:0] CAH_REG_CTRL = 8'h00;
    localparam logic [7:0] CAH_REG_TMO = 8'h04;
    localparam logic [7:0] CAH_REG_RLIM = 8'h08;
    localparam logic [7:0] CAH_REG_STAT = 8'h0C;
    localparam logic [7:0] CAH_REG_AWAIT = 8'h10;
    localparam logic [7:0] CAH_REG_SVC = 8'h14;
    localparam logic [7:0] CAH_REG_SVCARG = 8'h18;
    localparam logic [7:0] CAH_REG_ROUTE = 8'h1C;
    localparam logic [7:0] CAH_REG_RTLEN = 8'h20;
    // Control fields
    localparam int CAH_CTRL_DATA_EN = 0;
    localparam int CAH_CTRL_RESTART_BLOCK = 1;
    localparam int CAH_CTRL_RESTART_ALL = 2;
    // Route register fields
    localparam int CAH_SVCARG_LEN_LSB = 16;
    localparam logic [15:0] CAH_ID_NONE = 16'hFFFF;
    typedef enum logic [1:0] {
        CAH_IDLE = 2'b00,
        CAH_WAIT = 2'b01,
        CAH_DONE = 2'b10,
        CAH_LIMIT = 2'b11
    } cah_state_t;
endpackage : cah_pkg

// >>> rtl/cah_ack_timer.sv
`timescale 1ns/10ps
module cah_ack_timer (
    input wire logic mclk_i, // Module clock
    input wire logic rst_i, // Synchronous reset
    input wire logic start_i, // Restart the count
    input wire logic stop_i, // Stop without expiry
    input wire logic [31:0] load_i, // Time-out in cycles
    output logic run_o, // Counting
    output logic expire_o // One-cycle expiry pulse
);
    import cah_pkg::*;
    logic [31:0] cnt_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i || stop_i) begin
            cnt_q <= 32'h0;
            run_o <= 1'b0;
            expire_o <= 1'b0;
        end else if (start_i) begin
            // Zero load would never expire, so at least one cycle
            cnt_q <= (load_i == 32'h0) ? 32'h1 : load_i;
            run_o <= 1'b1;
            expire_o <= 1'b0;
        end else if (run_o && cnt_q == 32'h1) begin
            cnt_q <= 32'h0;
            run_o <= 1'b0;
            expire_o <= 1'b1;
        end else begin
            if (run_o) begin
                cnt_q <= cnt_q - 32'h1;
            end
            expire_o <= 1'b0;
        end
    end
endmodule : cah_ack_timer

// >>> rtl/cah_route_table.sv
`timescale 1ns/10ps
module cah_route_table #(
    parameter int NCONN = cah_pkg::CAH_NCONN
) (
    input wire logic mclk_i, // Module clock
    input wire logic rst_i, // Synchronous reset
    input wire logic add_i, // Add route pulse
    input wire logic del_i, // Remove route pulse
    input wire logic [15:0] id_i, // Connection instance for service
    input wire logic [15:0] len_i, // Route byte count
    input wire logic [63:0] route_i, // Route bytes
    input wire logic [15:0] look_id_i, // Connection for lookup
    output logic hit_o, // Lookup found a route
    output logic [63:0] route_o, // Route found
    output logic [15:0] len_o // Route length found
);
    import cah_pkg::*;
    logic [NCONN-1:0] used_q;
    logic [15:0] id_q [NCONN];
    logic [15:0] len_q [NCONN];
    logic [63:0] rt_q [NCONN];
    logic [NCONN-1:0] match;
    logic [NCONN-1:0] look;
    logic [NCONN-1:0] freeslot;
    genvar g;
    generate
        for (g = 0; g < NCONN; g++) begin : g_slot
            assign match[g] = used_q[g] && id_q[g] == id_i;
            assign look[g] = used_q[g] && id_q[g] == look_id_i;
        end
    endgenerate
    // Lowest free slot, used only if no entry for the id exists
    always_comb begin
        freeslot = '0;
        for (int i = NCONN - 1; i >= 0; i--) begin
            if (!used_q[i]) begin
                freeslot = '0;
                freeslot[i] = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NCONN; i++) begin
            if (rst_i) begin
                used_q[i] <= 1'b0;
                id_q[i] <= 16'h0;
                len_q[i] <= 16'h0;
                rt_q[i] <= 64'h0;
            end else if (add_i
                    && (match[i] || (match == '0 && freeslot[i]))) begin
                used_q[i] <= 1'b1;
                id_q[i] <= id_i;
                len_q[i] <= len_i;
                rt_q[i] <= route_i;
            end else if (del_i && match[i]) begin
                used_q[i] <= 1'b0;
            end
        end
    end
    always_comb begin
        hit_o = 1'b0;
        route_o = 64'h0;
        len_o = 16'h0;
        for (int i = 0; i < NCONN; i++) begin
            if (look[i]) begin
                hit_o = 1'b1;
                route_o = rt_q[i];
                len_o = len_q[i];
            end
        end
    end
endmodule : cah_route_table

// >>> rtl/cah_ack_handler.sv
// Overview of operation
// - Optional service 4B adds reply route
// - Optional service 4C deletes reply route
// - Add carries id, length, route bytes
// - Remove carries only connection id
// - Application reports each send and resend
// - Report missing acks at time-out
// - Any valid message on an established connection counts as ack
// - Forward ack payload along stored route
// - Every send or resend restarts timer
// - Timer expiry while waiting sends time-out message
// - Count time-outs; report limit reached
// - Send clears count; resend keeps it
// - Time-out and retry limit are configurable
// - Established connections join awaited list
// - Time-out defaults to 16 ms
// - Retry limit defaults to 1
`timescale 1ns/10ps
module cah_ack_handler #(
    parameter logic [31:0] ACK_TMO_CYC = cah_pkg::CAH_ACK_TMO_CYC,
    parameter int NCONN = cah_pkg::CAH_NCONN
) (
    input wire logic mclk_i, // Module clock
    input wire logic rst_i, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic data_sent_i, // New production pulse
    input wire logic data_resent_i, // Retry production pulse
    input wire logic conn_est_i, // Connection established pulse
    input wire logic conn_gone_i, // Connection left established pulse
    input wire logic [1:0] conn_slot_i, // Slot of that connection
    input wire logic [15:0] conn_id_i, // Its instance id
    input wire logic msg_valid_i, // Valid message on a connection
    input wire logic [1:0] msg_slot_i, // Slot it arrived on
    input wire logic [15:0] msg_len_i, // Its payload byte count
    output logic timeout_o, // Ack time-out message pulse
    output logic limit_o, // Retry limit reached pulse
    output logic ackd_o, // All awaited acks in
    output logic fwd_valid_o, // Payload forward pulse
    output logic [63:0] fwd_route_o, // Route for forwarded payload
    output logic [15:0] fwd_len_o // Forwarded payload length
);
    import cah_pkg::*;
    cah_state_t state_q;
    logic [31:0] tmo_q;
    logic [7:0] rlim_q;
    logic [7:0] rcnt_q;
    logic data_en_q;
    logic [NCONN-1:0] est_q;
    logic [NCONN-1:0] pend_q;
    logic [15:0] cid_q [NCONN];
    logic [15:0] svc_id_q;
    logic [15:0] svc_len_q;
    logic [63:0] route_q;
    logic add_q;
    logic del_q;
    logic tm_run;
    logic tm_exp;
    logic rt_hit;
    logic [63:0] rt_route;
    logic [15:0] rt_len;
    logic acc;
    logic wr;
    logic bad_addr;
    logic produce;
    logic msg_hit;

    function automatic logic addr_ok(input logic [7:0] a);
        return a == CAH_REG_CTRL || a == CAH_REG_TMO || a == CAH_REG_RLIM
            || a == CAH_REG_STAT || a == CAH_REG_AWAIT || a == CAH_REG_SVC
            || a == CAH_REG_SVCARG || a == CAH_REG_ROUTE
            || a == CAH_REG_RTLEN;
    endfunction : addr_ok

    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign bad_addr = !addr_ok(paddr);
    assign produce = data_sent_i || data_resent_i;
    assign msg_hit = msg_valid_i && est_q[msg_slot_i];

    // One wait state keeps prdata registered
    always_ff @(posedge mclk_i) begin
        if (rst_i || acc) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= bad_addr;
            prdata <= 32'h0;
            if (!pwrite) begin
                unique case (paddr)
                    CAH_REG_CTRL: prdata <= {31'h0, data_en_q};
                    CAH_REG_TMO: prdata <= tmo_q;
                    CAH_REG_RLIM: prdata <= {24'h0, rlim_q};
                    CAH_REG_STAT: prdata <= {22'h0, state_q, rcnt_q};
                    CAH_REG_AWAIT: prdata <= {24'h0, pend_q, est_q};
                    CAH_REG_SVCARG: prdata <= {svc_len_q, svc_id_q};
                    CAH_REG_ROUTE: prdata <= route_q[31:0];
                    CAH_REG_RTLEN: prdata <= route_q[63:32];
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tmo_q <= ACK_TMO_CYC;
            rlim_q <= CAH_RETRY_LIM_DEF;
            data_en_q <= 1'b0;
            svc_id_q <= 16'h0;
            svc_len_q <= 16'h0;
            route_q <= 64'h0;
        end else if (wr) begin
            unique case (paddr)
                CAH_REG_CTRL: data_en_q <= pwdata[CAH_CTRL_DATA_EN];
                CAH_REG_TMO: tmo_q <= pwdata;
                CAH_REG_RLIM: rlim_q <= pwdata[7:0];
                CAH_REG_SVCARG: begin
                    svc_id_q <= pwdata[15:0];
                    svc_len_q <= pwdata[31:CAH_SVCARG_LEN_LSB];
                end
                CAH_REG_ROUTE: route_q[31:0] <= pwdata;
                CAH_REG_RTLEN: route_q[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // Service write launches add or remove; other codes ignored
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            add_q <= 1'b0;
            del_q <= 1'b0;
        end else begin
            add_q <= wr && paddr == CAH_REG_SVC
                && pwdata[7:0] == CAH_SVC_ADD_ROUTE;
            del_q <= wr && paddr == CAH_REG_SVC
                && pwdata[7:0] == CAH_SVC_DEL_ROUTE;
        end
    end

    // Awaited list follows connection state
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NCONN; i++) begin
            if (rst_i) begin
                est_q[i] <= 1'b0;
                cid_q[i] <= 16'h0;
            end else if (conn_est_i && conn_slot_i == i[1:0]) begin
                est_q[i] <= 1'b1;
                cid_q[i] <= conn_id_i;
            end else if (conn_gone_i && conn_slot_i == i[1:0]) begin
                est_q[i] <= 1'b0;
            end
        end
    end

    // Pending acks: production sets, a valid message clears
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NCONN; i++) begin
            if (rst_i) begin
                pend_q[i] <= 1'b0;
            end else if (produce) begin
                pend_q[i] <= est_q[i];
            end else if (msg_hit && msg_slot_i == i[1:0]) begin
                pend_q[i] <= 1'b0;
            end
        end
    end

    cah_ack_timer u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(produce),
        .stop_i(state_q == CAH_WAIT && pend_q == '0 && !produce),
        .load_i(tmo_q),
        .run_o(tm_run),
        .expire_o(tm_exp)
    );

    cah_route_table #(.NCONN(NCONN)) u_routes (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .add_i(add_q),
        .del_i(del_q),
        .id_i(svc_id_q),
        .len_i(svc_len_q),
        .route_i(route_q),
        .look_id_i(cid_q[msg_slot_i]),
        .hit_o(rt_hit),
        .route_o(rt_route),
        .len_o(rt_len)
    );

    // Handler state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= CAH_IDLE;
            rcnt_q <= 8'h0;
            timeout_o <= 1'b0;
            limit_o <= 1'b0;
            ackd_o <= 1'b0;
        end else begin
            timeout_o <= 1'b0;
            limit_o <= 1'b0;
            ackd_o <= 1'b0;
            if (data_sent_i) begin
                rcnt_q <= 8'h0;
                state_q <= CAH_WAIT;
            end else if (data_resent_i) begin
                if (state_q != CAH_LIMIT) begin
                    state_q <= CAH_WAIT;
                end
            end else begin
                unique case (state_q)
                    CAH_IDLE, CAH_DONE, CAH_LIMIT: ;
                    CAH_WAIT: begin
                        if (pend_q == '0) begin
                            state_q <= CAH_DONE;
                            ackd_o <= 1'b1;
                        end else if (tm_exp) begin
                            timeout_o <= 1'b1;
                            rcnt_q <= rcnt_q + 8'h1;
                            if (rcnt_q + 8'h1 >= rlim_q) begin
                                limit_o <= 1'b1;
                                state_q <= CAH_LIMIT;
                            end else begin
                                state_q <= CAH_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Payload forwarding
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_route_o <= 64'h0;
            fwd_len_o <= 16'h0;
        end else begin
            fwd_valid_o <= msg_hit && data_en_q && rt_hit
                && msg_len_i != 16'h0;
            if (msg_hit) begin
                fwd_route_o <= rt_route;
                fwd_len_o <= msg_len_i;
            end
        end
    end

    property p_limit;
        @(posedge mclk_i) disable iff (rst_i)
        timeout_o && rcnt_q >= rlim_q |-> limit_o;
    endproperty
    // Expiry that counts as a time-out, no production competing
    sequence s_expiry;
        tm_exp && state_q == CAH_WAIT && pend_q != '0 && !produce;
    endsequence
    sequence s_limit_hit;
        s_expiry ##0 rcnt_q + 8'h1 >= rlim_q;
    endsequence
    sequence s_all_in;
        state_q == CAH_WAIT && pend_q == '0 && !produce;
    endsequence
    sequence s_resend_blocked;
        state_q == CAH_LIMIT && data_resent_i && !data_sent_i;
    endsequence
    tmo_count_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_expiry |=> timeout_o && rcnt_q == $past(rcnt_q) + 8'h1)
        else $error("time-out not counted");
    limit_msg_a: assert property (p_limit)
        else $error("limit message missing");
    limit_state_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_limit_hit |=> limit_o && state_q == CAH_LIMIT)
        else $error("limit state not entered");
    sent_clear_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        data_sent_i |=> rcnt_q == 8'h0)
        else $error("send did not clear count");
    resent_keep_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        data_resent_i && !data_sent_i |=> $stable(rcnt_q))
        else $error("resend changed count");
    timer_start_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        produce |=> tm_run)
        else $error("timer not restarted");
    limit_hold_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        state_q == CAH_LIMIT && !data_sent_i |=> state_q == CAH_LIMIT)
        else $error("left limit without send");
    resend_block_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_resend_blocked |=> !timeout_o && !limit_o)
        else $error("resend acted after limit");
    ack_clear_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        msg_hit && !produce |=> !pend_q[$past(msg_slot_i)])
        else $error("ack not taken");
    ack_done_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_all_in |=> ackd_o && !tm_run && state_q == CAH_DONE)
        else $error("all acks in not reported");
    est_join_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        conn_est_i |=> est_q[$past(conn_slot_i)])
        else $error("connection not awaited");
    pend_load_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        produce |=> pend_q == $past(est_q))
        else $error("awaited list not loaded");
    fwd_gate_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        fwd_valid_o |-> $past(data_en_q) && $past(rt_hit))
        else $error("forward without route");
    fwd_data_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        msg_hit && data_en_q && rt_hit && msg_len_i != 16'h0
        |=> fwd_valid_o && fwd_route_o == $past(rt_route)
            && fwd_len_o == $past(msg_len_i))
        else $error("payload not forwarded");
    cfg_load_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr && paddr == CAH_REG_TMO |=> tmo_q == $past(pwdata))
        else $error("time-out not written");
    rlim_load_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr && paddr == CAH_REG_RLIM |=> rlim_q == $past(pwdata[7:0]))
        else $error("retry limit not written");
    svc_add_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr && paddr == CAH_REG_SVC && pwdata[7:0] == CAH_SVC_ADD_ROUTE
        |=> add_q && !del_q)
        else $error("add service not launched");
    reset_dflt_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $fell(rst_i) |-> tmo_q == ACK_TMO_CYC && rlim_q == CAH_RETRY_LIM_DEF)
        else $error("defaults not loaded");
endmodule : cah_ack_handler

// >>> test/cah_consumer_model.sv
`timescale 1ns/10ps
module cah_consumer_model (
    input wire logic mclk_i, // Module clock
    input wire logic rst_i, // Synchronous reset
    input wire logic go_i, // Production seen on the link
    input wire logic mute_i, // Withhold the answer
    input wire logic [7:0] dly_i, // Answer delay in cycles
    input wire logic [1:0] slot_i, // Slot to answer on
    input wire logic [15:0] len_i, // Reply byte count
    output logic msg_valid_o, // Answer message pulse
    output logic [1:0] msg_slot_o, // Answer slot
    output logic [15:0] msg_len_o // Answer byte count
);
    // Server trigger code of the consuming connection
    localparam logic [7:0] CAH_TRIG_SERVER = 8'h83;
    int cnt;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            cnt <= 0;
            msg_valid_o <= 1'b0;
            msg_slot_o <= 2'h0;
            msg_len_o <= 16'h0;
        end else begin
            msg_valid_o <= 1'b0;
            // Unqualified lines wander so stale values cannot pass
            msg_slot_o <= ~msg_slot_o;
            msg_len_o <= ~msg_len_o;
            if (go_i && !mute_i) begin
                cnt <= int'(dly_i) + 1;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                msg_valid_o <= 1'b1;
                msg_slot_o <= slot_i;
                msg_len_o <= len_i;
            end
        end
    end
endmodule : cah_consumer_model

// >>> test/cah_ack_handler_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cah_ack_handler_tb;
    import cah_pkg::*;
    localparam logic [31:0] TMO = 32'h14;
    logic mclk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, data_sent_i = 1'b0, data_resent_i = 1'b0;
    logic conn_est_i = 1'b0, mute = 1'b1, msg_valid_i, er, lim_seen;
    logic pready, pslverr, timeout_o, limit_o, ackd_o, fwd_valid_o;
    logic [7:0] paddr = 8'h00, dly = 8'h03;
    logic [1:0] msg_slot_i;
    logic [15:0] conn_id_i = 16'h0005, a_len = 16'h0000;
    logic [15:0] msg_len_i, fwd_len_o, f_len;
    logic [31:0] pwdata = 32'h0, prdata, rd, w0, w1, rnd = 32'hA408;
    logic [63:0] fwd_route_o, f_route, f_exp, fq[$];
    int m_rcnt = 0, m_rlim = 1;
    int error_cnt = 0, checks = 0, n_to = 0, n_ack = 0, n_fwd = 0, cyc, cnt;

    cah_ack_handler #(.ACK_TMO_CYC(TMO), .NCONN(CAH_NCONN)) cah_ack_handler_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .data_sent_i(data_sent_i),
        .data_resent_i(data_resent_i), .conn_est_i(conn_est_i),
        .conn_gone_i(1'b0), .conn_slot_i(2'h0), .conn_id_i(conn_id_i),
        .msg_valid_i(msg_valid_i), .msg_slot_i(msg_slot_i),
        .msg_len_i(msg_len_i), .timeout_o(timeout_o), .limit_o(limit_o),
        .ackd_o(ackd_o), .fwd_valid_o(fwd_valid_o),
        .fwd_route_o(fwd_route_o), .fwd_len_o(fwd_len_o));

    cah_consumer_model cah_consumer_model_i (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .go_i(data_sent_i | data_resent_i),
        .mute_i(mute), .dly_i(dly), .slot_i(2'h0), .len_i(a_len),
        .msg_valid_o(msg_valid_i),
        .msg_slot_o(msg_slot_i),
        .msg_len_o(msg_len_i));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs

    task automatic results();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK(pready, 1'b1)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk

    // Kinds: 0 new data, 1 retry, 2 connection established
    task automatic ev(input int k);
        @(posedge mclk_i);
        case (k)
            0: begin
                data_sent_i <= 1'b1;
                m_rcnt = 0;
            end
            1: data_resent_i <= 1'b1;
            default: conn_est_i <= 1'b1;
        endcase
        @(posedge mclk_i);
        data_sent_i <= 1'b0;
        data_resent_i <= 1'b0;
        conn_est_i <= 1'b0;
    endtask : ev

    task automatic wev();
        int s;
        s = n_to + n_ack;
        cyc = 0;
        while (n_to + n_ack == s && cyc < 500) begin
            @(posedge mclk_i);
            cyc++;
        end
        if (cyc >= 500) `CHK(cyc, 0)
    endtask : wev

    // Pulses are caught mid-cycle, away from the launching edge
    always @(negedge mclk_i) begin
        if (!rst_i) begin
            if (timeout_o === 1'b1) begin
                n_to++;
                lim_seen = limit_o;
                m_rcnt++;
                `CHK(limit_o, 1'(m_rcnt >= m_rlim))
            end else if (limit_o !== 1'b0) `CHK(limit_o, 1'b0)
            if (ackd_o === 1'b1) n_ack++;
            if (fwd_valid_o === 1'b1) begin
                n_fwd++;
                f_route = fwd_route_o;
                f_len = fwd_len_o;
                f_exp = (fq.size() > 0) ? fq.pop_front() : 64'h0;
                `CHK(f_route, f_exp)
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        results();
    end

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk(CAH_REG_TMO, TMO);
        rchk(CAH_REG_RLIM, 32'h1);
        rchk(8'h3C, 32'h0);
        `CHK(er, 1'b1)
        ev(2);
        rchk(CAH_REG_AWAIT, 32'h1);
        ev(0);
        wev();
        `CHK(lim_seen, 1'b1)
        rchk(CAH_REG_STAT, 32'h301);
        ev(1);
        rchk(CAH_REG_STAT, 32'h301);
        apb(1'b1, CAH_REG_RLIM, 32'h3);
        m_rlim = 3;
        cnt = 0;
        ev(0);
        rchk(CAH_REG_STAT, 32'h100);
        // A time-out below the limit returns to idle with acks still pending
        for (int i = 0; i < 3; i++) begin
            wev();
            cnt++;
            `CHK(lim_seen, 1'(cnt >= 3))
            rchk(CAH_REG_STAT, {22'h0, ((cnt >= 3) ? 2'h3 : 2'h0),
                 8'(m_rcnt)});
            if (cnt < 3) ev(1);
        end
        w0 = 32'h8 + (xs() & 32'hF);
        apb(1'b1, CAH_REG_TMO, w0);
        ev(0);
        wev();
        `CHK(cyc >= w0 - 1 && cyc <= w0 + 6, 1'b1)
        mute <= 1'b0;
        dly <= 8'(xs() & 32'h7);
        apb(1'b1, CAH_REG_TMO, TMO);
        ev(0);
        wev();
        `CHK(n_ack, 1)
        `CHK(n_to, 5)
        rchk(CAH_REG_STAT, 32'h200);
        w0 = xs();
        w1 = xs();
        apb(1'b1, CAH_REG_SVCARG, {16'h0004, conn_id_i});
        apb(1'b1, CAH_REG_ROUTE, w0);
        apb(1'b1, CAH_REG_RTLEN, w1);
        apb(1'b1, CAH_REG_SVC, {24'h0, CAH_SVC_ADD_ROUTE});
        apb(1'b1, CAH_REG_CTRL, 32'h1);
        a_len <= 16'h0004;
        fq.push_back({w1, w0});
        ev(0);
        wev();
        repeat (2) @(posedge mclk_i);
        `CHK(n_fwd, 1)
        `CHK(f_route, {w1, w0})
        `CHK(f_len, 16'h0004)
        apb(1'b1, CAH_REG_SVCARG, {16'h0, conn_id_i});
        apb(1'b1, CAH_REG_SVC, {24'h0, CAH_SVC_DEL_ROUTE});
        ev(0);
        wev();
        repeat (2) @(posedge mclk_i);
        `CHK(n_fwd, 1)
        `CHK(n_ack, 3)
        `CHK(fq.size(), 0)
        results();
    end
endmodule : cah_ack_handler_tb
